// ---- src/flc_pkg.sv ----
// constants, types and helpers for the flash led control logic
package flc_pkg;
  localparam int CLK_MHZ       = 250;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SPIKE_NS      = 50;
  localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int FLASH_TO0_US  = 110000;
  localparam int FLASH_TO1_US  = 220000;
  localparam int FLASH_TO2_US  = 530000;
  localparam int FLASH_TO3_US  = 1100000;
  localparam int TMR_W         = 21;

  localparam logic [6:0] TGT_ADDR = 7'h28;

  localparam logic [1:0] REG_CTRL  = 2'h0;
  localparam logic [1:0] REG_VSTAT = 2'h1;
  localparam logic [1:0] REG_FLASH = 2'h2;
  localparam logic [1:0] REG_TORCH = 2'h3;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_RET     = 5;
  localparam int CTRL_GAIN_LO = 3;
  localparam int CTRL_TO_LO   = 0;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  localparam logic [1:0] MODE_TORCH = 2'h1;

  localparam int VSTAT_V_LO = 5;
  localparam int VSTAT_RDY  = 4;
  localparam int VSTAT_UVLO = 1;
  localparam int VSTAT_OT   = 0;

  localparam int LED_EN_LO  = 5;
  localparam int LED_LVL_LO = 0;

  localparam logic [13:0] VLIM_BASE_MV  = 14'h11C6;
  localparam logic [13:0] VLIM_STEP_MV  = 14'h0096;
  localparam logic [13:0] VLIM_TORCH_MV = 14'h1194;
  localparam logic [13:0] RDY_MARGIN_MV = 14'h0064;

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} flc_i2c_state_t;
  typedef enum {PH_ADDR, PH_PTR, PH_DATA} flc_phase_t;

  // flash-mode output voltage limit in mV, 4550 + 150 per code
  function automatic logic [13:0] flc_vlim_mv(input logic [2:0] code);
    logic [13:0] step;
    step = 14'(code) * VLIM_STEP_MV;
    return VLIM_BASE_MV + step;
  endfunction : flc_vlim_mv
endpackage : flc_pkg

// ---- src/flc_in_filter.sv ----
// two-flop synchroniser with per-bit stability filter
`timescale 1ns/1ps
module flc_in_filter #(
  parameter int W      = 1,
  parameter int STABLE = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  localparam int CW = $clog2(STABLE + 1);
  logic [W-1:0]  s1;
  logic [W-1:0]  s2;
  logic [CW-1:0] cnt [W];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      for (int i = 0; i < W; i++) cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == q[i])
          cnt[i] <= '0;
        else if (cnt[i] == CW'(STABLE - 1))
        begin
          q[i]   <= s2[i];
          cnt[i] <= '0;
        end
        else
          cnt[i] <= CW'(cnt[i] + 1'b1);
      end
    end
  end
endmodule : flc_in_filter

// ---- src/flc_flash_timer.sv ----
// flash interval timer on a 1 us prescaler tick
`timescale 1ns/1ps
module flc_flash_timer #(
  parameter int TO0 = 1,
  parameter int TO1 = 1,
  parameter int TO2 = 1,
  parameter int TO3 = 1
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [1:0] sel,
  output logic            active
);
  import flc_pkg::*;
  logic [7:0]       pre;
  logic             tick;
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] lim;

  always_comb
  begin
    unique case (sel)
      2'h0: lim = TMR_W'(TO0);
      2'h1: lim = TMR_W'(TO1);
      2'h2: lim = TMR_W'(TO2);
      2'h3: lim = TMR_W'(TO3);
    endcase
  end

  assign tick = (pre == 8'(TICK_CYC - 1));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre <= 8'h00;
    else if (!active || tick)
      pre <= 8'h00;
    else
      pre <= 8'(pre + 1'b1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active <= 1'b0;
      cnt    <= '0;
    end
    else if (abort)
    begin
      active <= 1'b0;
      cnt    <= '0;
    end
    else if (start && !active)
    begin
      active <= 1'b1;
      cnt    <= '0;
    end
    else if (active && tick)
    begin
      // a shorter code chosen mid-flash still ends the interval
      if (cnt >= TMR_W'(lim - 1'b1))
        active <= 1'b0;
      cnt <= TMR_W'(cnt + 1'b1);
    end
  end

  property p_flash_len;
    @(posedge sys_clk) disable iff (!rst_n)
    active && tick && !abort && cnt >= TMR_W'(lim - 1'b1) |=> !active;
  endproperty
  a_flash_len: assert property (p_flash_len)
    else $error("flash interval did not end at selected length");

  property p_flash_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    active && !abort && cnt < TMR_W'(lim - 1'b1) |=> active;
  endproperty
  a_flash_hold: assert property (p_flash_hold)
    else $error("flash interval ended early");
endmodule : flc_flash_timer

// ---- src/flc_top.sv ----
// flash led control logic: i2c target, registers, flash and ready
`timescale 1ns/1ps
module flc_top #(
  parameter int FLASH_TO0_TICKS = flc_pkg::FLASH_TO0_US * 1000 / flc_pkg::TICK_NS,
  parameter int FLASH_TO1_TICKS = flc_pkg::FLASH_TO1_US * 1000 / flc_pkg::TICK_NS,
  parameter int FLASH_TO2_TICKS = flc_pkg::FLASH_TO2_US * 1000 / flc_pkg::TICK_NS,
  parameter int FLASH_TO3_TICKS = flc_pkg::FLASH_TO3_US * 1000 / flc_pkg::TICK_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        shdn_n,
  input  wire logic        flash_trig,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [12:0] vout_mv,
  input  wire logic [2:0]  led_short,
  input  wire logic        fault_uvlo,
  input  wire logic        fault_ot,
  output logic      [2:0]  led_en,
  output logic      [4:0]  led_level,
  output logic      [1:0]  gain,
  output logic             pump_en,
  output logic             rdy
);
  import flc_pkg::*;

  logic           scl_f;
  logic           sda_f;
  logic           scl_q;
  logic           sda_q;
  logic           shdn_s;
  logic           trig_s;
  logic           trig_q;
  logic           uvlo_s;
  logic           ot_s;
  logic [2:0]     short_s;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_c;
  logic           stop_c;
  flc_i2c_state_t state;
  flc_phase_t     phase;
  logic           rw;
  logic [3:0]     bcnt;
  logic [7:0]     sh;
  logic [1:0]     ptr;
  logic           wr_en;
  logic [1:0]     wr_idx;
  logic [7:0]     wr_data;
  logic [7:0]     rd_byte;
  logic [7:0]     ctrl;
  logic [2:0]     vsel;
  logic [7:0]     flash_r;
  logic [7:0]     torch_r;
  logic [1:0]     mode;
  logic           flash_mode;
  logic           torch_mode;
  logic           flash_on;
  logic           flash_go;
  logic [13:0]    lim;

  flc_in_filter #(
    .W      (2),
    .STABLE (SPIKE_CYC)
  ) u_bus_filt (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({scl_i, sda_i}),
    .q       ({scl_f, sda_f})
  );

  flc_in_filter #(
    .W      (7),
    .STABLE (1)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({shdn_n, flash_trig, fault_uvlo, fault_ot, led_short}),
    .q       ({shdn_s, trig_s, uvlo_s, ot_s, short_s})
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q  <= 1'b0;
      sda_q  <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      scl_q  <= scl_f;
      sda_q  <= sda_f;
      trig_q <= trig_s;
    end
  end

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_c  = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_c   = scl_f & scl_q & ~sda_q & sda_f;
  assign sda_o    = 1'b0;

  always_comb
  begin
    unique case (ptr)
      REG_CTRL:  rd_byte = ctrl;
      REG_VSTAT: rd_byte = {vsel, rdy, 2'b00, uvlo_s, ot_s};
      REG_FLASH: rd_byte = flash_r;
      REG_TORCH: rd_byte = torch_r;
    endcase
  end

  // i2c target: address, pointer, then data with auto increment
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= ST_IDLE;
      phase   <= PH_ADDR;
      rw      <= 1'b0;
      bcnt    <= 4'h0;
      sh      <= 8'h00;
      ptr     <= 2'h0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_idx  <= 2'h0;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if (start_c)
      begin
        state  <= ST_RX;
        phase  <= PH_ADDR;
        bcnt   <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (state)
          ST_IDLE: ;
          ST_RX:
          begin
            if (scl_rise)
            begin
              sh   <= {sh[6:0], sda_f};
              bcnt <= 4'(bcnt + 1'b1);
            end
            else if (scl_fall && bcnt == 4'h8)
            begin
              if (phase == PH_ADDR && sh[7:1] != TGT_ADDR)
                state <= ST_IDLE;
              else
              begin
                sda_oe <= 1'b1;
                state  <= ST_ACK;
                unique case (phase)
                  PH_ADDR: rw <= sh[0];
                  PH_PTR:  ptr <= sh[1:0];
                  PH_DATA:
                  begin
                    wr_en   <= 1'b1;
                    wr_idx  <= ptr;
                    wr_data <= sh;
                    ptr     <= 2'(ptr + 1'b1);
                  end
                endcase
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              bcnt <= 4'h0;
              if (phase == PH_ADDR && rw)
              begin
                state  <= ST_TX;
                sh     <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ptr    <= 2'(ptr + 1'b1);
              end
              else
              begin
                state  <= ST_RX;
                sda_oe <= 1'b0;
                phase  <= (phase == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bcnt == 4'h7)
              begin
                sda_oe <= 1'b0;
                state  <= ST_RACK;
              end
              else
              begin
                sh     <= {sh[6:0], 1'b0};
                bcnt   <= 4'(bcnt + 1'b1);
                sda_oe <= ~sh[6];
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise && sda_f)
              state <= ST_IDLE;
            else if (scl_fall)
            begin
              state  <= ST_TX;
              bcnt   <= 4'h0;
              sh     <= rd_byte;
              sda_oe <= ~rd_byte[7];
              ptr    <= 2'(ptr + 1'b1);
            end
          end
        endcase
      end
    end
  end

  // register file and shutdown handling
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl    <= REG_RESET;
      vsel    <= REG_RESET[2:0];
      flash_r <= REG_RESET;
      torch_r <= REG_RESET;
    end
    else if (!shdn_s && !ctrl[CTRL_RET])
    begin
      ctrl    <= REG_RESET;
      vsel    <= REG_RESET[2:0];
      flash_r <= REG_RESET;
      torch_r <= REG_RESET;
    end
    else if (wr_en && shdn_s)
    begin
      unique case (wr_idx)
        REG_CTRL:  ctrl <= wr_data;
        REG_VSTAT: vsel <= wr_data[VSTAT_V_LO +: 3];
        REG_FLASH: flash_r <= wr_data;
        REG_TORCH: torch_r <= wr_data;
      endcase
    end
  end

  assign mode       = ctrl[CTRL_MODE_LO +: 2];
  assign flash_mode = (mode == MODE_FLASH);
  assign torch_mode = (mode == MODE_TORCH);
  assign gain       = ctrl[CTRL_GAIN_LO +: 2];
  assign flash_go   = shdn_s & flash_mode & trig_s & ~trig_q;

  flc_flash_timer #(
    .TO0 (FLASH_TO0_TICKS),
    .TO1 (FLASH_TO1_TICKS),
    .TO2 (FLASH_TO2_TICKS),
    .TO3 (FLASH_TO3_TICKS)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (flash_go),
    .abort   (~shdn_s | ~flash_mode),
    .sel     (ctrl[CTRL_TO_LO +: 2]),
    .active  (flash_on)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_en    <= 3'h0;
      led_level <= 5'h00;
      pump_en   <= 1'b0;
    end
    else if (!shdn_s)
    begin
      led_en    <= 3'h0;
      led_level <= 5'h00;
      pump_en   <= 1'b0;
    end
    else
    begin
      pump_en <= flash_mode | torch_mode;
      if (flash_mode)
      begin
        led_en    <= flash_on ? flash_r[LED_EN_LO +: 3] & ~short_s : 3'h0;
        led_level <= flash_r[LED_LVL_LO +: 5];
      end
      else if (torch_mode)
      begin
        led_en    <= torch_r[LED_EN_LO +: 3] & ~short_s;
        led_level <= torch_r[LED_LVL_LO +: 5];
      end
      else
      begin
        led_en    <= 3'h0;
        led_level <= 5'h00;
      end
    end
  end

  assign lim = flash_mode ? flc_vlim_mv(vsel) : VLIM_TORCH_MV;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdy <= 1'b0;
    else
      rdy <= shdn_s & ((14'(vout_mv) + RDY_MARGIN_MV) >= lim);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_shdn_off;
    !shdn_s |=> led_en == 3'h0 && !pump_en && led_level == 5'h00;
  endproperty
  a_shdn_off: assert property (p_shdn_off)
    else $error("drivers active during shutdown");

  property p_shdn_clear;
    !shdn_s && !ctrl[CTRL_RET] |=> ctrl == 8'h00 && flash_r == 8'h00
      && torch_r == 8'h00 && vsel == 3'h0;
  endproperty
  a_shdn_clear: assert property (p_shdn_clear)
    else $error("registers not cleared in shutdown");

  property p_shdn_keep;
    !shdn_s && ctrl[CTRL_RET] |=> $stable(ctrl) && $stable(flash_r)
      && $stable(torch_r) && $stable(vsel);
  endproperty
  a_shdn_keep: assert property (p_shdn_keep)
    else $error("retained registers changed in shutdown");

  property p_flash_start;
    flash_go && !flash_on |=> flash_on ##1 (led_en == ($past(flash_r[LED_EN_LO +: 3])
      & ~$past(short_s)) || !$past(flash_mode) || !$past(shdn_s));
  endproperty
  a_flash_start: assert property (p_flash_start)
    else $error("trigger did not light flash");

  property p_rdy;
    shdn_s && (14'(vout_mv) + RDY_MARGIN_MV >= lim) |=> rdy;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready low near limit");

  property p_rdy_torch;
    shdn_s && torch_mode && (14'(vout_mv) + RDY_MARGIN_MV < VLIM_TORCH_MV) |=> !rdy;
  endproperty
  a_rdy_torch: assert property (p_rdy_torch)
    else $error("ready high below torch limit");

  property p_rdy_drop;
    $fell(shdn_s) |-> ##1 !rdy;
  endproperty
  a_rdy_drop: assert property (p_rdy_drop)
    else $error("ready not dropped at shutdown");

  property p_torch_src;
    shdn_s && torch_mode |=> led_en == ($past(torch_r[LED_EN_LO +: 3]) & ~$past(short_s))
      && led_level == $past(torch_r[LED_LVL_LO +: 5]);
  endproperty
  a_torch_src: assert property (p_torch_src)
    else $error("torch current source mismatch");

  property p_short;
    short_s != 3'h0 |=> (led_en & $past(short_s)) == 3'h0;
  endproperty
  a_short: assert property (p_short)
    else $error("shorted channel still enabled");

  property p_addr;
    state == ST_RX && phase == PH_ADDR && scl_fall && bcnt == 4'h8
      && sh[7:1] != TGT_ADDR && !start_c && !stop_c |=> !sda_oe && state == ST_IDLE;
  endproperty
  a_addr: assert property (p_addr)
    else $error("acknowledged foreign address");

  property p_no_restart;
    !flash_on && trig_s && trig_q |=> !flash_on;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("held trigger restarted flash");
endmodule : flc_top

// ---- verif/flc_host_model.sv ----
// behavioural i2c controller for the block's serial pins
`timescale 1ns/1ps
module flc_host_model (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  import flc_pkg::*;

  logic spike = 1'b0;

  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // one link phase, a quarter of a bit
  task automatic q();
    repeat (16) @(posedge sys_clk);
  endtask : q

  // one bit; optional short pulses that the target must ignore
  task automatic bit_io(input logic d, output logic s);
    if (spike)
    begin
      scl <= 1'b1;
      repeat (10) @(posedge sys_clk);
      scl <= 1'b0;
    end
    sda_drv <= d;
    q();
    scl <= 1'b1;
    q();
    s = sda_line;
    if (spike)
    begin
      sda_drv <= ~d;
      repeat (10) @(posedge sys_clk);
      sda_drv <= d;
    end
    q();
    scl <= 1'b0;
    q();
  endtask : bit_io

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : xfer

  task automatic start();
    sda_drv <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask : start

  task automatic stop();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b1;
    repeat (2) q();
  endtask : stop

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({a, 1'b0}, rx, a0);
    xfer(p, rx, a1);
    xfer(d, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({TGT_ADDR, 1'b0}, rx, a0);
    xfer(p, rx, a1);
    start();
    xfer({TGT_ADDR, 1'b1}, rx, a2);
    ok = a0 & a1 & a2;
    xfer(8'hFF, d, a0);
    stop();
  endtask : rd
endmodule : flc_host_model

// ---- verif/flc_top_tb.sv ----
// self-checking bench for the flash led control logic
`timescale 1ns/1ps
module flc_top_tb;
  import flc_pkg::*;

  localparam int TO [4] = '{4, 6, 8, 10};

  logic        sys_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        shdn_n     = 1'b1;
  logic        flash_trig = 1'b0;
  logic [12:0] vout_mv    = 13'h0000;
  logic [2:0]  led_short  = 3'h0;
  logic        fault_uvlo = 1'b0;
  logic        fault_ot   = 1'b0;
  logic        scl;
  logic        sda_drv;
  logic        sda_o;
  logic        sda_oe;
  logic        sda_line;
  logic        pump_en;
  logic        rdy;
  logic [2:0]  led_en;
  logic [4:0]  led_level;
  logic [1:0]  gain;
  logic        ok;
  logic [7:0]  rdat;
  logic [13:0] lim;
  logic [2:0]  en_seen;
  logic [4:0]  lvl_seen;
  int          bad_count = 0;
  int          checked   = 0;
  int          cycles    = 0;
  int          on;

  // open-drain wire with pull-up
  assign sda_line = sda_oe ? (sda_o & sda_drv) : sda_drv;

  flc_top #(
    .FLASH_TO0_TICKS(4),
    .FLASH_TO1_TICKS(6),
    .FLASH_TO2_TICKS(8),
    .FLASH_TO3_TICKS(10)
  ) flc_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .shdn_n(shdn_n), .flash_trig(flash_trig),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .vout_mv(vout_mv), .led_short(led_short), .fault_uvlo(fault_uvlo),
    .fault_ot(fault_ot), .led_en(led_en), .led_level(led_level), .gain(gain),
    .pump_en(pump_en), .rdy(rdy)
  );

  flc_host_model flc_host_model_i (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
  );

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      $display("[FAIL] run_length expected end got hang");
      summarize();
    end
  end

  task automatic chk(input string n, input logic [12:0] exp, input logic [12:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h got %h", n, exp, got);
    end
  endtask : chk

  task automatic wclk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wclk

  task automatic wreg(input logic [1:0] r, input logic [7:0] d);
    flc_host_model_i.wr(TGT_ADDR, {6'h00, r}, d, ok);
    chk("write_ack", 13'h1, 13'(ok));
  endtask : wreg

  task automatic rreg(input logic [1:0] r, input logic [7:0] e, input logic [7:0] m);
    flc_host_model_i.rd({6'h00, r}, rdat, ok);
    chk("read_ack", 13'h1, 13'(ok));
    chk("read_data", 13'(e & m), 13'(rdat & m));
  endtask : rreg

  task automatic shut_check();
    chk("pre_shdn_rdy", 13'h1, 13'(rdy));
    shdn_n <= 1'b0;
    wclk(6);
    chk("shdn_rdy", 13'h0, 13'(rdy));
    chk("shdn_outputs", 13'h0, {4'h0, led_en, led_level, pump_en});
    shdn_n <= 1'b1;
    wclk(8);
  endtask : shut_check

  initial
  begin
    wclk(8);
    rst_n <= 1'b1;
    wclk(40);
    flc_host_model_i.wr(7'h29, 8'h00, 8'h41, ok);
    chk("foreign_ack", 13'h0, 13'(ok));
    wreg(REG_FLASH, 8'h3F);
    flc_host_model_i.spike = 1'b1;
    wreg(REG_TORCH, 8'hAA);
    flc_host_model_i.spike = 1'b0;
    wreg(REG_CTRL, 8'h40);
    wclk(8);
    chk("torch_en", 13'h5, 13'(led_en));
    chk("torch_level", 13'h0A, 13'(led_level));
    led_short <= 3'h1;
    wclk(8);
    chk("short_en", 13'h4, 13'(led_en));
    led_short <= 3'h0;
    vout_mv <= VLIM_TORCH_MV[12:0] - RDY_MARGIN_MV[12:0] - 13'h0001;
    wclk(4);
    chk("rdy_torch_below", 13'h0, 13'(rdy));
    vout_mv <= VLIM_TORCH_MV[12:0] - RDY_MARGIN_MV[12:0];
    wclk(4);
    chk("rdy_torch_at", 13'h1, 13'(rdy));
    wreg(REG_CTRL, 8'hC0);
    fault_uvlo <= 1'b1;
    for (int c = 0; c < 8; c += 3)
    begin
      lim = VLIM_BASE_MV + 14'(c) * VLIM_STEP_MV - RDY_MARGIN_MV;
      wreg(REG_VSTAT, {c[2:0], 5'h00});
      vout_mv <= lim[12:0] - 13'h0001;
      wclk(4);
      chk("rdy_flash_below", 13'h0, 13'(rdy));
      vout_mv <= lim[12:0];
      wclk(4);
      chk("rdy_flash_at", 13'h1, 13'(rdy));
      rreg(REG_VSTAT, {c[2:0], 5'h12}, 8'hF3);
    end
    vout_mv <= 13'h0000;
    for (int k = 0; k < 4; k++)
    begin
      wreg(REG_CTRL, {6'h30, k[1:0]});
      flash_trig <= 1'b1;
      on = 0;
      en_seen = 3'h0;
      lvl_seen = 5'h00;
      // held trigger spans the interval and beyond
      repeat (TO[k] * TICK_CYC + 700)
      begin
        @(posedge sys_clk);
        if (led_en !== 3'h0)
        begin
          on++;
          en_seen = led_en;
          lvl_seen = led_level;
        end
      end
      chk("flash_length", 13'h1, 13'(on >= TO[k] * TICK_CYC - 1 && on <= TO[k] * TICK_CYC + 1));
      chk("flash_en", 13'h1, 13'(en_seen));
      chk("flash_level", 13'h1F, 13'(lvl_seen));
      flash_trig <= 1'b0;
      wclk(8);
    end
    wreg(REG_CTRL, 8'h98);
    wclk(8);
    chk("mode10_off", 13'h0, {9'h000, led_en, pump_en});
    chk("gain", 13'h3, 13'(gain));
    rreg(REG_CTRL, 8'h98, 8'hFF);
    wreg(REG_CTRL, 8'h40);
    vout_mv <= VLIM_TORCH_MV[12:0];
    wclk(4);
    shut_check();
    rreg(REG_CTRL, 8'h00, 8'hFF);
    rreg(REG_TORCH, 8'h00, 8'hFF);
    wreg(REG_TORCH, 8'hAA);
    wreg(REG_CTRL, 8'h60);
    wclk(4);
    shut_check();
    rreg(REG_CTRL, 8'h60, 8'hFF);
    rreg(REG_TORCH, 8'hAA, 8'hFF);
    chk("resume_en", 13'h5, 13'(led_en));
    summarize();
  end
endmodule : flc_top_tb
